// >>> src/dsscp_regs.svh
`ifndef DSSCP_REGS_SVH
`define DSSCP_REGS_SVH
// word layout of one serial command
`define DSSCP_BIT_WATCHDOG  15
`define DSSCP_BIT_PARITY    14
`define DSSCP_BIT_BANK      13
`define DSSCP_ADDR_HI       12
`define DSSCP_ADDR_LO       10
`define DSSCP_DATA_HI       9
// input register addresses (word bits 12:10)
`define DSSCP_SI_READBACK   3'h0
`define DSSCP_SI_PWM        3'h1
`define DSSCP_SI_OUTCONF    3'h2
`define DSSCP_SI_OCCONF     3'h4
`define DSSCP_SI_RETRY      3'h5
`define DSSCP_SI_GLOBAL     3'h6
`define DSSCP_SI_CALIB      3'h7
// output register addresses (readback select bits 2:0)
`define DSSCP_SO_STATUS     3'h0
`define DSSCP_SO_FAULT      3'h1
`define DSSCP_SO_PWM        3'h2
`define DSSCP_SO_OUTCONF    3'h3
`define DSSCP_SO_OCCONF     3'h4
`define DSSCP_SO_RETRY      3'h5
`define DSSCP_SO_GLOBAL     3'h6
`define DSSCP_SO_DIAG       3'h7
// field positions inside output data
`define DSSCP_FAULT_PREWARN 8
`define DSSCP_DIAG_ID_LO    5
// fixed data pattern that makes a calibration write count
`define DSSCP_CALIB_KEY     10'h15b
// reset value of every input register data field
`define DSSCP_DATA_RESET    10'h000
`endif

// >>> src/dsscp_pkg.sv
`default_nettype none
package dsscp_pkg;
    // state kept on the system clock
    typedef struct packed {
        logic             csb_meta;      // select pin, first stage
        logic             csb_sync;      // select pin, second stage
        logic             csb_last;      // select pin, edge history
        logic             tog_meta;      // frame toggle, first stage
        logic             tog_sync;      // frame toggle, second stage
        logic             tog_seen;      // toggle value at last frame end
        logic [1:0]       on_meta;       // channel state, first stage
        logic [1:0]       on_sync;       // channel state, second stage
        logic             warn_meta;     // temperature warn, first stage
        logic             warn_sync;     // temperature warn, second stage
        logic [1:0][9:0]  readback_select;
        logic [1:0][9:0]  pwm_duty_control;
        logic [1:0][9:0]  output_configuration;
        logic [1:0][9:0]  overcurrent_configuration;
        logic [1:0][9:0]  autoretry_configuration;
        logic [9:0]       global_configuration;
        logic [1:0]       cal_pulse;     // calibration start per bank
        logic             rb_bank;       // bank of next returned register
        logic [2:0]       rb_addr;       // address of next returned register
        logic             prewarn;       // thermal prewarning flag
        logic             wd_bit;        // last accepted watchdog bit
        logic             par_fault;     // last full-length frame had a parity error
        logic [15:0]      tx_word;       // word shifted out next frame
    } dsscp_sys_t;

    // state kept on the serial clock
    typedef struct packed {
        logic [3:0]       bit_mod;       // bits in frame, modulo 16
        logic             first_done;    // sixteen bits seen this frame
        logic             frame_tog;     // flips on first bit of a frame
        logic [15:0]      rx_sr;         // last sixteen bits received
    } dsscp_link_t;
endpackage
`default_nettype wire

// >>> src/dsscp_core.sv
// How it works
// - sixteen-bit words, most significant bit first
// - bit 14 makes word parity even
// - bit 13 picks channel bank
// - bits 12 to 10 pick input register
// - bits 9 to 0 are register data
// - bad length or parity leaves registers alone
// - transfers only while reset pin high
// - select falling starts shifting out and in
// - first word out is previously selected register
// - select rising validates then latches word
// - output floats once select rises, status refreshed after latch
// - input echoes to output sixteen bits later
// - second word out is first word in
// - several words allowed per select frame
// - thirteen input and thirteen output registers
// - per-channel registers exist once per bank
// - prewarning sticky until read while cool
// - status bits 0,1 show channel on state
// - output word bits 13:10 carry its address
`timescale 1ns/10ps
`default_nettype none
`include "dsscp_regs.svh"

module dsscp_core
#(
    parameter logic [1:0] P_PART_ID = 2'h0   // arbitrary value
)
(
    input  wire logic            i_clock,           // system clock 10 MHz
    input  wire logic            i_rst_n,           // reset pin, active low
    input  wire logic            i_spi_clock,       // serial clock
    input  wire logic            i_select_low_pin,  // frame select, low
    input  wire logic            i_spi_si,          // serial data in
    output logic                 o_spi_so,          // serial data out
    output logic                 o_spi_so_oe_n,     // so enable, low drives
    input  wire logic [1:0]      i_channel_on,      // channel above half supply
    input  wire logic            i_temp_warn,       // over prewarning threshold
    output logic [1:0][9:0]      o_pwm_duty_control,          // per bank
    output logic [1:0][9:0]      o_output_configuration,      // per bank
    output logic [1:0][9:0]      o_overcurrent_configuration, // per bank
    output logic [1:0][9:0]      o_autoretry_configuration,   // per bank
    output logic [9:0]           o_global_configuration,      // shared
    output logic [1:0]           o_calibration_start,         // pulse
    output logic                 o_thermal_prewarning_flag,   // sticky flag
    output logic                 o_watchdog_toggle_bit        // last wd bit
);

    dsscp_pkg::dsscp_sys_t   sys_ff;      // system clock state
    dsscp_pkg::dsscp_sys_t   nxt_sys;     // its next value
    dsscp_pkg::dsscp_link_t  link_ff;     // serial clock state
    dsscp_pkg::dsscp_link_t  nxt_link;    // its next value
    logic                    in_frame_ff; // a serial edge seen this frame
    logic                    frame_clr;   // clears in_frame_ff
    logic [3:0]              out_idx;     // bit of tx_word on the pin

    // decoded view of the frame that just ended
    logic                    frame_end;   // select rose, one cycle
    logic                    had_bits;    // at least one edge in frame
    logic                    len_ok;      // whole number of words
    logic                    parity_ok;   // even count of ones
    logic                    word_ok;     // word may be latched
    logic                    csb_idle;    // select high and settled
    logic                    wr_bank;     // bank of received word
    logic [2:0]              wr_addr;     // address of received word
    logic [9:0]              wr_data;     // data of received word
    logic                    fault_read;  // fault register left the pin

    // ------------------------------------------------------------------
    // serial clock domain
    // ------------------------------------------------------------------

    // the serial clock stops between frames, so a new frame is seen by
    // this flag alone, which the select pin clears while high
    assign frame_clr = ~i_rst_n | i_select_low_pin;

    // first edge marks the frame start
    always_ff @(posedge i_spi_clock or posedge frame_clr)
    begin
        if (frame_clr)
        begin
            in_frame_ff <= 1'b0;
        end
        else
        begin
            in_frame_ff <= 1'b1;
        end
    end

    // next state of the shifter and bit counter
    always_comb
    begin
        nxt_link = link_ff;
        // shift in most significant bit first
        nxt_link.rx_sr = {link_ff.rx_sr[14:0], i_spi_si};
        if (!in_frame_ff)
        begin
            // first edge of a frame: restart the count
            nxt_link.bit_mod    = 4'h1;
            nxt_link.first_done = 1'b0;
            nxt_link.frame_tog  = ~link_ff.frame_tog;
        end
        else
        begin
            // counting wraps, so many words fit one frame
            nxt_link.bit_mod = 4'(link_ff.bit_mod + 4'h1);
            if (link_ff.bit_mod == 4'hf)
            begin
                nxt_link.first_done = 1'b1;
            end
        end
    end

    // counter and shifter keep their value after the frame so the
    // system side can read them once the select edge has crossed
    always_ff @(posedge i_spi_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            link_ff <= '0;
        end
        else
        begin
            link_ff <= nxt_link;
        end
    end

    // bit of the prepared word on the pin; before the first edge it is
    // the most significant one
    assign out_idx = in_frame_ff ? 4'(4'hf - link_ff.bit_mod) : 4'hf;

    // first word comes from the prepared register word
    // later bits are the input delayed by sixteen edges
    // so the second word out is the first word in
    assign o_spi_so = (in_frame_ff && link_ff.first_done)
                      ? link_ff.rx_sr[15]
                      : sys_ff.tx_word[out_idx];

    // drive only inside a frame and out of reset
    assign o_spi_so_oe_n = i_select_low_pin | ~i_rst_n;

    // ------------------------------------------------------------------
    // system clock domain
    // ------------------------------------------------------------------

    // frame end seen through the synchronised select
    assign frame_end = sys_ff.csb_sync & ~sys_ff.csb_last;
    assign csb_idle  = sys_ff.csb_sync & sys_ff.csb_last;
    // a frame with no clock edge leaves the toggle where it was
    assign had_bits  = sys_ff.tog_sync ^ sys_ff.tog_seen;

    // serial state is quiet here: the clock stopped before select rose
    // length must be a whole, non-zero number of words
    assign len_ok    = had_bits & link_ff.first_done &
                       (link_ff.bit_mod == 4'h0);
    // whole word must hold an even count of ones
    assign parity_ok = ~(^link_ff.rx_sr);
    assign word_ok   = frame_end & len_ok & parity_ok;

    assign wr_bank   = link_ff.rx_sr[`DSSCP_BIT_BANK];
    assign wr_addr   = link_ff.rx_sr[`DSSCP_ADDR_HI:`DSSCP_ADDR_LO];
    assign wr_data   = link_ff.rx_sr[`DSSCP_DATA_HI:0];

    // the fault register was shifted out in the frame that just ended
    assign fault_read = frame_end & had_bits &
                        (sys_ff.rb_addr == `DSSCP_SO_FAULT);

    // data field of one output register; bit 9 always reads zero
    function automatic logic [9:0] out_data(
        input dsscp_pkg::dsscp_sys_t st,
        input logic                  bank,
        input logic [2:0]            addr
    );
        logic [9:0] d;
        d = 10'h000;
        case (addr)
            // live channel state in bits 1:0
            `DSSCP_SO_STATUS:  d = {8'h00, st.on_sync};
            `DSSCP_SO_FAULT:   d[`DSSCP_FAULT_PREWARN] = st.prewarn;
            `DSSCP_SO_PWM:     d = {1'b0, st.pwm_duty_control[bank][8:0]};
            `DSSCP_SO_OUTCONF:
                d = {1'b0, st.output_configuration[bank][8:0]};
            `DSSCP_SO_OCCONF:
                d = {1'b0, st.overcurrent_configuration[bank][8:0]};
            `DSSCP_SO_RETRY:
                d = {1'b0, st.autoretry_configuration[bank][8:0]};
            `DSSCP_SO_GLOBAL:  d = {1'b0, st.global_configuration[8:0]};
            `DSSCP_SO_DIAG:    d[`DSSCP_DIAG_ID_LO +: 2] = P_PART_ID;
            default:           d = 10'h000;
        endcase
        return d;
    endfunction

    // status, global and diag registers have no bank copy, so they report bank zero; fault keeps the selected bank
    function automatic logic bank_of(
        input logic       bank,
        input logic [2:0] addr
    );
        logic b;
        b = bank;
        if (addr == `DSSCP_SO_STATUS || addr == `DSSCP_SO_GLOBAL ||
            addr == `DSSCP_SO_DIAG)
        begin
            b = 1'b0;
        end
        return b;
    endfunction

    // next state of the register file and the reply word
    always_comb
    begin
        nxt_sys = sys_ff;
        // two-flop synchronisers for everything from outside
        nxt_sys.csb_meta  = i_select_low_pin;
        nxt_sys.csb_sync  = sys_ff.csb_meta;
        nxt_sys.csb_last  = sys_ff.csb_sync;
        nxt_sys.tog_meta  = link_ff.frame_tog;
        nxt_sys.tog_sync  = sys_ff.tog_meta;
        nxt_sys.on_meta   = i_channel_on;
        nxt_sys.on_sync   = sys_ff.on_meta;
        nxt_sys.warn_meta = i_temp_warn;
        nxt_sys.warn_sync = sys_ff.warn_meta;
        nxt_sys.cal_pulse = 2'h0;

        if (frame_end)
        begin
            nxt_sys.tog_seen = sys_ff.tog_sync;
            // parity result is reported for every full-length frame
            if (len_ok)
            begin
                nxt_sys.par_fault = ~parity_ok;
            end
        end

        if (word_ok)
        begin
            nxt_sys.wd_bit = link_ff.rx_sr[`DSSCP_BIT_WATCHDOG];
            // one copy per bank, global register shared
            case (wr_addr)
                `DSSCP_SI_READBACK:
                begin
                    nxt_sys.readback_select[wr_bank] = wr_data;
                    // pick the register for the next frame
                    nxt_sys.rb_bank = wr_bank;
                    nxt_sys.rb_addr = wr_data[2:0];
                end
                `DSSCP_SI_PWM:
                    nxt_sys.pwm_duty_control[wr_bank] = wr_data;
                `DSSCP_SI_OUTCONF:
                    nxt_sys.output_configuration[wr_bank] = wr_data;
                `DSSCP_SI_OCCONF:
                    nxt_sys.overcurrent_configuration[wr_bank] = wr_data;
                `DSSCP_SI_RETRY:
                    nxt_sys.autoretry_configuration[wr_bank] = wr_data;
                `DSSCP_SI_GLOBAL:
                    nxt_sys.global_configuration = wr_data;
                `DSSCP_SI_CALIB:
                begin
                    // a wrong pattern is taken but starts nothing
                    if (wr_data == `DSSCP_CALIB_KEY)
                    begin
                        nxt_sys.cal_pulse[wr_bank] = 1'b1;
                    end
                end
                default:
                begin
                    // address 3 has no register; only the watchdog bit is kept
                end
            endcase
        end

        // set wins; a read clears only once temperature is low
        nxt_sys.prewarn = sys_ff.warn_sync |
                          (sys_ff.prewarn & ~fault_read);

        // refresh the reply while the synchronised select is high; it lags
        // the pin by two cycles, so the word can still change as a frame opens
        if (csb_idle)
        begin
            // address of the returned register in bits 13:10
            nxt_sys.tx_word = {
                sys_ff.wd_bit,
                sys_ff.par_fault,
                bank_of(sys_ff.rb_bank, sys_ff.rb_addr),
                sys_ff.rb_addr,
                out_data(sys_ff, sys_ff.rb_bank, sys_ff.rb_addr)
            };
        end
    end

    // every register clears while the reset pin is low, except the select stages, which reset high
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            sys_ff <= '0;
            sys_ff.csb_meta <= 1'b1;
            sys_ff.csb_sync <= 1'b1;
            sys_ff.csb_last <= 1'b1;
        end
        else
        begin
            sys_ff <= nxt_sys;
        end
    end

    // register outputs
    assign o_pwm_duty_control          = sys_ff.pwm_duty_control;
    assign o_output_configuration      = sys_ff.output_configuration;
    assign o_overcurrent_configuration = sys_ff.overcurrent_configuration;
    assign o_autoretry_configuration   = sys_ff.autoretry_configuration;
    assign o_global_configuration      = sys_ff.global_configuration;
    assign o_calibration_start         = sys_ff.cal_pulse;
    assign o_thermal_prewarning_flag   = sys_ff.prewarn;
    // the master toggles it; the latest value is exposed here
    assign o_watchdog_toggle_bit       = sys_ff.wd_bit;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------

    sequence s_bad_parity;
        frame_end && len_ok && !parity_ok;
    endsequence

    sequence s_bad_length;
        frame_end && !len_ok;
    endsequence

    sequence s_pwm_write;
        word_ok && (wr_addr == `DSSCP_SI_PWM);
    endsequence

    sequence s_select_write;
        word_ok && (wr_addr == `DSSCP_SI_READBACK);
    endsequence

    // the synchronised select lags the pin by two cycles, so a frame
    // that has just opened still looks idle there; watch the pin itself
    chk_idle_so_float: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        i_select_low_pin |-> o_spi_so_oe_n
    ) else $error("so driven while select high");

    chk_parity_drop_regs: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        s_bad_parity |=> $stable(sys_ff.pwm_duty_control) &&
                         $stable(sys_ff.global_configuration) &&
                         (sys_ff.par_fault == 1'b1)
    ) else $error("bad parity word changed registers");

    chk_length_drop_regs: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        s_bad_length |=> $stable(sys_ff.output_configuration) &&
                         $stable(sys_ff.rb_addr) &&
                         (o_calibration_start == 2'h0)
    ) else $error("bad length frame changed registers");

    chk_pwm_write_lands: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        s_pwm_write |=> sys_ff.pwm_duty_control[$past(wr_bank)] ==
                        $past(wr_data)
    ) else $error("valid pwm write not stored");

    chk_readback_pick: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        s_select_write ##1 csb_idle |=>
            sys_ff.tx_word[12:10] == $past(wr_data[2:0], 2)
    ) else $error("reply word not from selected register");

    chk_status_live: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        csb_idle && $past(csb_idle) &&
        (sys_ff.rb_addr == `DSSCP_SO_STATUS) |->
            sys_ff.tx_word[1:0] == $past(sys_ff.on_sync)
    ) else $error("status bits do not follow channels");

    chk_prewarn_sets: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        sys_ff.warn_sync |=> o_thermal_prewarning_flag
    ) else $error("prewarning flag missed a warning");

    chk_prewarn_sticky: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        sys_ff.prewarn && !fault_read |=> o_thermal_prewarning_flag
    ) else $error("prewarning flag cleared without a read");

    chk_calib_one_pulse: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        word_ok && (wr_addr == `DSSCP_SI_CALIB) &&
        (wr_data == `DSSCP_CALIB_KEY) |=>
            o_calibration_start[$past(wr_bank)] ##1
            (o_calibration_start == 2'h0)
    ) else $error("calibration start not a single pulse");

    chk_so_echo: assert property (
        @(posedge i_spi_clock) disable iff (frame_clr)
        in_frame_ff && link_ff.first_done |->
            o_spi_so == $past(i_spi_si, 16)
    ) else $error("so is not si delayed sixteen bits");

endmodule

`default_nettype wire

// >>> sim/dsscp_spi_master.sv
`timescale 1ns/10ps
`default_nettype none

// master on the far side; its clock runs only inside frames
module dsscp_spi_master
(
    output logic      o_sclk,    // link clock, idle low
    output logic      o_sel_n,   // frame select, active low
    output logic      o_si,      // data towards the port
    input  wire logic i_so,      // data from the port
    input  wire logic i_so_oe_n  // low while the port drives
);
    localparam int HALF = 24;    // half of the 48 ns link period

    initial
    begin
        o_sclk = 1'b0;
        o_sel_n = 1'b1;
        o_si = 1'b0;
    end

    task automatic xfer(input logic [31:0] d, input int n,
                        output logic [31:0] q, output logic drv);
        drv = 1'b1;
        q = '0;
        #7;
        o_sel_n = 1'b0;
        for (int i = n - 1; i >= 0; i--)
        begin
            o_si = d[i];
            #HALF;
            // sample just before the rising edge
            drv &= ~i_so_oe_n;
            // a floating line reads as the inverse of what it last held
            q = {q[30:0], i_so_oe_n ? ~i_so : i_so};
            o_sclk = 1'b1;
            #HALF;
            o_sclk = 1'b0;
        end
        #HALF;
        o_sel_n = 1'b1;
        // released line must not keep a stale value
        o_si = ~o_si;
    endtask
endmodule
`default_nettype wire

// >>> sim/testbench.sv
`timescale 1ns/10ps
`default_nettype none

module testbench;
    logic            clk, rst_n, sclk, sel_n, si, so, so_oe_n, warn;
    logic [1:0]      ch_on;                        // channel state in
    logic [1:0][9:0] pwm, outc, occ, rty;          // register outputs
    logic [1:0][9:0] s_pwm, s_outc, s_occ, s_rty;  // expected copies
    logic [9:0]      glb, s_glb;                   // shared register
    logic            flag, s_flag, wd, s_wd;       // flags
    logic [1:0]      cal;                          // calibration pulses
    logic [31:0]     rx;                           // last reply
    logic            drv;                          // port drove in frame
    int              cal_n [2];                    // pulses per bank
    int              failures;
    int              n_compared;

    dsscp_core u_dsscp_core
    (
        .i_clock(clk), .i_rst_n(rst_n), .i_spi_clock(sclk),
        .i_select_low_pin(sel_n), .i_spi_si(si), .o_spi_so(so),
        .o_spi_so_oe_n(so_oe_n), .i_channel_on(ch_on),
        .i_temp_warn(warn), .o_pwm_duty_control(pwm),
        .o_output_configuration(outc),
        .o_overcurrent_configuration(occ),
        .o_autoretry_configuration(rty),
        .o_global_configuration(glb), .o_calibration_start(cal),
        .o_thermal_prewarning_flag(flag), .o_watchdog_toggle_bit(wd)
    );

    dsscp_spi_master u_dsscp_spi_master
    (
        .o_sclk(sclk), .o_sel_n(sel_n), .o_si(si),
        .i_so(so), .i_so_oe_n(so_oe_n)
    );

    // 10 MHz system clock
    always #50 clk = ~clk;

    // one-cycle pulses are counted so none is missed
    always @(posedge clk)
    begin
        if (cal[0])
            cal_n[0]++;
        if (cal[1])
            cal_n[1]++;
    end

    function automatic logic [15:0] mk(input logic w, input logic b,
                                       input logic [2:0] a,
                                       input logic [9:0] d);
        logic [15:0] x;
        x = {w, 1'b0, b, a, d};
        x[14] = ^x;
        return x;
    endfunction

    task automatic final_report();
        if (failures == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] e,
                            input logic [31:0] m);
        n_compared++;
        if ((got & m) !== (e & m))
        begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, e);
        end
    endtask

    task automatic cmp_st();
        n_compared++;
        if ({pwm, outc, occ, rty, glb, flag, wd} !==
            {s_pwm, s_outc, s_occ, s_rty, s_glb, s_flag, s_wd})
        begin
            failures++;
            $display("unexpected at %0t: register outputs", $time);
        end
    endtask

    // one frame; the copies move only when the frame is valid
    task automatic wr(input logic b, input logic [2:0] a,
                      input logic [9:0] d, input logic [31:0] flip,
                      input int n);
        logic [15:0] w;
        // each word flips the watchdog bit
        w = mk(~s_wd, b, a, d);
        u_dsscp_spi_master.xfer({16'h0, w} ^ flip, n, rx, drv);
        repeat (6) @(negedge clk);
        if (flip == 0 && n == 16)
        begin
            s_wd = w[15];
            case (a)
                3'h1: s_pwm[b] = d;
                3'h2: s_outc[b] = d;
                3'h4: s_occ[b] = d;
                3'h5: s_rty[b] = d;
                3'h6: s_glb = d;
                default: ;
            endcase
        end
        cmp_word({30'h0, so_oe_n, drv}, 32'h3, 32'h3);
        cmp_st();
    endtask

    task automatic t_write();
        for (int a = 0; a < 7; a++)
            for (int b = 0; b < 2; b++)
                wr(b[0], a[2:0], {b[0], a[2:0], 6'h2d}, 0, 16);
    endtask

    task automatic t_reject();
        wr(1'b0, 3'h1, 10'h3c3, 32'h4000, 16);
        wr(1'b0, 3'h1, 10'h3c3, 32'h0, 15);
        wr(1'b0, 3'h1, 10'h3c3, 32'h0, 17);
        wr(1'b0, 3'h2, 10'h111, 32'h0, 16);
        cmp_word(rx, 32'h4000, 32'h4000);
    endtask

    task automatic t_echo();
        logic [15:0] w1, w2;
        w1 = mk(~s_wd, 1'b0, 3'h1, 10'h155);
        w2 = mk(~w1[15], 1'b1, 3'h1, 10'h2aa);
        u_dsscp_spi_master.xfer({w1, w2}, 32, rx, drv);
        repeat (6) @(negedge clk);
        s_wd = w2[15];
        s_pwm[1] = 10'h2aa;
        cmp_word(rx, {16'h0, w1}, 32'hffff);
        cmp_st();
    endtask

    task automatic t_readback();
        logic [31:0] e;
        wr(1'b1, 3'h0, 10'h002, 32'h0, 16);
        e = {16'h0, s_wd, 2'b01, 3'h2, 1'b0, s_pwm[1][8:0]};
        wr(1'b0, 3'h6, 10'h001, 32'h0, 16);
        cmp_word(rx, e, 32'hffff);
    endtask

    task automatic t_status();
        wr(1'b0, 3'h0, 10'h000, 32'h0, 16);
        for (int i = 1; i < 3; i++)
        begin
            ch_on = i[1:0];
            repeat (4) @(negedge clk);
            wr(1'b0, 3'h6, 10'h0a5, 32'h0, 16);
            cmp_word(rx, {16'h0, ~s_wd, 13'h0, i[1:0]}, 32'hfc03);
        end
    endtask

    task automatic t_warn();
        logic [31:0] e;
        warn = 1'b1;
        repeat (4) @(negedge clk);
        s_flag = 1'b1;
        warn = 1'b0;
        wr(1'b0, 3'h0, 10'h001, 32'h0, 16);
        e = {16'h0, s_wd, 5'h1, 10'h100};
        s_flag = 1'b0;
        wr(1'b0, 3'h6, 10'h000, 32'h0, 16);
        cmp_word(rx, e, 32'hfd00);
    endtask

    task automatic t_calib();
        int c0, c1;
        c0 = cal_n[0];
        c1 = cal_n[1];
        wr(1'b1, 3'h7, 10'h15b, 32'h0, 16);
        wr(1'b1, 3'h7, 10'h15a, 32'h0, 16);
        cmp_word({16'(cal_n[1] - c1), 16'(cal_n[0] - c0)},
                 32'h0001_0000, '1);
    endtask

    task automatic t_rst();
        rst_n = 1'b0;
        u_dsscp_spi_master.xfer({16'h0, mk(~s_wd, 1'b0, 3'h1, 10'h0ff)},
                                16, rx, drv);
        @(negedge clk);
        cmp_word({31'h0, drv}, 32'h0, '1);
        {s_pwm, s_outc, s_occ, s_rty, s_glb, s_flag, s_wd} = '0;
        cmp_st();
        rst_n = 1'b1;
        repeat (6) @(negedge clk);
        cmp_st();
        wr(1'b0, 3'h1, 10'h0ff, 32'h0, 16);
    endtask

    initial
    begin
        clk = 1'b0;
        rst_n = 1'b0;
        ch_on = 2'b00;
        warn = 1'b0;
        cal_n = '{0, 0};
        failures = 0;
        n_compared = 0;
        {s_pwm, s_outc, s_occ, s_rty, s_glb, s_flag, s_wd} = '0;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        cmp_st();
        t_write();
        t_reject();
        t_echo();
        t_readback();
        t_status();
        t_warn();
        t_calib();
        t_rst();
        final_report();
    end

    // cut a hang well beyond the expected run of about 45 us
    initial
    begin
        #2_000_000;
        failures++;
        final_report();
    end
endmodule
`default_nettype wire
